// >>> sbw_checker.sv
/*
 * Link checker for both ends.
 * Assumes baud register 7 (8-cycle bits) and 8-cycle remote bits.
 */
module sbw_checker (
    input logic pclk,
    input logic presetn,
    input logic dev_dt_o,
    input logic dev_dt_oe,
    input logic dev_ck_o,
    input logic dev_ck_oe,
    input logic rem_dt_o,
    input logic rem_dt_oe,
    input logic ck
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] low_run;
    logic [3:0] quiet;
    logic [4:0] edges;
    logic       ck_q;
    wire        tgl = dev_ck_o != ck_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Eight quiet cycles close a synchronous character
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_run <= 8'h00;
            quiet   <= 4'h0;
            edges   <= 5'h00;
            ck_q    <= 1'b1;
        end else begin
            low_run <= (ck || dev_dt_oe) ? 8'h00 : low_run + 8'h01;
            quiet   <= tgl ? 4'h0 : quiet + {3'h0, quiet != 4'h8};
            edges   <= (!dev_dt_oe || quiet == 4'h8) ? 5'h00
                                                     : edges + {4'h0, tgl};
            ck_q    <= dev_ck_o;
        end
    end

    a_start_bit_len: assert property (
        $fell(ck) && !dev_dt_oe |=> !ck [*7]) else $error("short low bit");
    a_break_max_low: assert property (
        low_run <= 8'h68) else $error("break longer than 13 bits");
    a_sync_data_lead: assert property (
        dev_dt_oe && $past(dev_dt_oe) && $changed(dev_dt_o)
        |-> $changed(dev_ck_o)) else $error("data moved off clock edge");
    a_sync_half_period: assert property (
        dev_dt_oe && $past(dev_dt_oe) && $changed(dev_ck_o)
        |=> $stable(dev_ck_o) [*7]) else $error("half period too short");
    a_sync_clock_count: assert property (
        edges <= 5'h10) else $error("extra clock in character");
    a_sync_oe_pair: assert property (
        dev_dt_oe |-> dev_ck_oe) else $error("data driven without clock");
    a_rem_start_len: assert property (
        $rose(rem_dt_oe) |-> !rem_dt_o [*8]) else $error("short start");
    a_rem_stop_high: assert property (
        $fell(rem_dt_oe) |-> $past(rem_dt_o)) else $error("no stop bit");

    c_long_break: cover property (low_run == 8'h68);
    c_full_char: cover property (edges == 5'h10);
    c_remote_frame: cover property ($rose(rem_dt_oe));
endmodule // sbw_checker

// >>> sbw_link_if.sv
/*
 * Data line resolved from each end's enables, clock line from the port's.
 * Assumes pull-ups on both lines.
 */
interface sbw_link_if;
    logic dev_dt_o;
    logic dev_dt_oe;
    logic dev_ck_o;
    logic dev_ck_oe;
    logic rem_dt_o;
    logic rem_dt_oe;
    logic dt;
    logic ck;

    // Pull-up when undriven; the port wins a clash on the data line
    assign dt = dev_dt_oe ? dev_dt_o : (rem_dt_oe ? rem_dt_o : 1'b1);
    assign ck = dev_ck_oe ? dev_ck_o : 1'b1;

    modport dev (output dev_dt_o, dev_dt_oe, dev_ck_o, dev_ck_oe,
                 input  dt);
    modport rem (output rem_dt_o, rem_dt_oe,
                 input  dt, ck);
endinterface

// >>> sbw_pkg.sv
/*
 * Constants shared by both ends, and the port's state types.
 * Assumes 32-bit APB with byte addresses.
 */
package sbw_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int          ADDR_W   = 8;
    localparam logic [7:0]  OFS_CTRL = 8'h00;
    localparam logic [7:0]  OFS_STAT = 8'h04;
    localparam logic [7:0]  OFS_TXD  = 8'h08;
    localparam logic [7:0]  OFS_RXD  = 8'h0c;
    localparam logic [7:0]  OFS_BAUD = 8'h10;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int CTRL_W   = 9;
    localparam int CB_PEN   = 0;    // port_enable
    localparam int CB_SYNC  = 1;    // synchronous select
    localparam int CB_MCS   = 2;    // master_clock_source
    localparam int CB_TRANSMIT_ENABLE  = 3;    // transmit_enable
    localparam int CB_SBRK  = 4;    // send_break
    localparam int CB_WUE   = 5;    // wake_on_break_enable
    localparam int CB_POL   = 6;    // clock_polarity_select
    localparam int CB_SINGLE_RECEIVE_ENABLE  = 7;    // single_receive_enable
    localparam int CB_CONTINUOUS_RECEIVE_ENABLE  = 8;    // continuous_receive_enable
    localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;

    // ------------------------------------------------------------
    // Status fields
    // ------------------------------------------------------------
    localparam int SB_RFLAG = 0;    // receive_flag
    localparam int SB_FRAMING_ERROR_FLAG  = 1;    // framing_error_flag
    localparam int SB_RIDLE = 2;    // receiver_idle_status
    localparam int SB_TSE   = 3;    // transmit_shift_empty
    localparam int SB_TBE   = 4;    // transmit_buffer_empty_flag
    localparam int STAT_W   = 5;

    // ------------------------------------------------------------
    // Character and timing figures
    // ------------------------------------------------------------
    localparam int          DATA_W      = 8;
    localparam int          BAUD_W      = 16;
    localparam logic [15:0] BAUD_DEF    = 16'h0007;
    localparam logic [3:0]  CHAR_BITS   = 4'h8;
    localparam logic [3:0]  BREAK_ZEROS = 4'hc;
    localparam int          TX_SH_W     = 13;
    localparam int          WAKE_MIN_BITS  = 10;
    localparam int          LIN_BREAK_BITS = 13;
    localparam int          REM_BIT_CYCLES = 8;

    typedef enum logic [2:0] {
        TX_IDLE, TX_ASYNC, TX_STOP, TX_LEAD, TX_TRAIL, TX_END
    } sbw_tx_t;

    typedef enum logic [1:0] {
        RX_IDLE, RX_START, RX_DATA, RX_STOP
    } sbw_rx_t;

endpackage

// >>> sbw_port.sv
/*
 * Serial port: APB slave, async break/wake, sync master.
 * Assumes link lines from another domain.
 */
// Functional notes
// RULE_01 - Wake armed: receiver idle, watches line only
// RULE_02 - Line falling edge wakes, sets receive flag
// RULE_03 - Wake flag raised on system clock here
// RULE_04 - Reading receive data clears the flag
// RULE_05 - Line rising edge clears wake enable
// RULE_06 - Wake works only in asynchronous mode
// RULE_07 - Nonzero char: first low pulse wakes
// RULE_08 - Remote wake character: zeros, 10+ bits
// RULE_09 - Software checks receiver idle before arming
// RULE_10 - Break: start, twelve zeros, stop
// RULE_11 - Send-break write sends zeros, ignores value
// RULE_12 - Send-break self-clears after break stop bit
// RULE_13 - Shift-empty tracks breaks like characters
// RULE_14 - Header: dummy write, then 55h write
// RULE_15 - Break received: flag, framing error, 00h
// RULE_16 - Wake edges flag, next byte flags again
// RULE_17 - Synchronous: half-duplex, no start/stop bits
// RULE_18 - Master transmit needs sync, source, enable
// RULE_19 - One master clock per data bit
// RULE_20 - Polarity sets idle level and change edge
// RULE_21 - Holding register waits for empty shifter
// RULE_22 - Master drives both lines, leading-edge data
// RULE_23 - Synchronous characters go LSB first
module sbw_port
    import sbw_pkg::*;
#(
    parameter logic [BAUD_W-1:0] BAUD_RESET = BAUD_DEF
) (
    input  logic              pclk,
    input  logic              presetn,
    input  logic [ADDR_W-1:0] paddr,
    input  logic              psel,
    input  logic              penable,
    input  logic              pwrite,
    input  logic [31:0]       pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    sbw_link_if.dev           link
);
    // Half a bit time must be at least one cycle
    if (BAUD_RESET < 1) begin : g_chk_baud
        $error("BAUD_RESET must be at least 1");
    end

    // ------------------------------------------------------------
    // Registers and decode
    // ------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl;
    logic [BAUD_W-1:0] baud;
    logic [DATA_W-1:0] hold;
    logic              hold_v;
    logic [DATA_W-1:0] rx_data;
    logic              rflag;
    logic              framing_error_flag;
    sbw_tx_t           txs;
    sbw_rx_t           rxs;

    wire pen  = ctrl[CB_PEN];
    wire sync = ctrl[CB_SYNC];
    wire mcs  = ctrl[CB_MCS];
    wire transmit_enable = ctrl[CB_TRANSMIT_ENABLE];
    wire sbrk = ctrl[CB_SBRK];
    wire wake_on_break_enable  = ctrl[CB_WUE];
    wire pol  = ctrl[CB_POL];
    wire single_receive_enable = ctrl[CB_SINGLE_RECEIVE_ENABLE];
    wire continuous_receive_enable = ctrl[CB_CONTINUOUS_RECEIVE_ENABLE];

    wire acc      = psel & penable & pready;
    wire wr       = acc & pwrite;
    wire rd       = acc & !pwrite;
    wire hit_ctrl = paddr == OFS_CTRL;
    wire hit_stat = paddr == OFS_STAT;
    wire hit_txd  = paddr == OFS_TXD;
    wire hit_rxd  = paddr == OFS_RXD;
    wire hit_baud = paddr == OFS_BAUD;
    wire mapped   = hit_ctrl | hit_stat | hit_txd | hit_rxd | hit_baud;
    wire rd_rxd   = rd & hit_rxd;

    wire [STAT_W-1:0] stat = {!hold_v, txs == TX_IDLE,  // [RULE_13]
                              rxs == RX_IDLE, framing_error_flag, rflag};
    wire [31:0] rd_mux = hit_ctrl ? 32'(ctrl)    :
                         hit_stat ? 32'(stat)    :
                         hit_rxd  ? 32'(rx_data) :
                         hit_baud ? 32'(baud)    : 32'h0000_0000;

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & !pready;
            pslverr <= psel & penable & !pready & !mapped;
            if (psel & penable & !pready)
                prdata <= pwrite ? '0 : rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Receive line sampling and wake detection
    // ------------------------------------------------------------
    logic dts;
    logic dtp;

    sbw_sync u_dt (.clk(pclk), .rst_n(presetn), .d(link.dt), .q(dts));

    wire fell     = dtp & !dts;
    wire rose     = !dtp & dts;
    wire wake_arm = wake_on_break_enable & pen & !sync;       // [RULE_06]
    wire wake_ev  = wake_arm & fell;         // [RULE_02] [RULE_03] [RULE_07]
    wire wake_end = wake_arm & rose;         // [RULE_05]

    // ------------------------------------------------------------
    // Transmit control
    // ------------------------------------------------------------
    logic [TX_SH_W-1:0] tx_sh;
    logic [3:0]         tx_bits;
    logic [BAUD_W-1:0]  tx_cnt;
    logic               tx_brk;

    wire tx_tick  = tx_cnt == '0;
    wire sync_tx  = pen & sync & mcs & !single_receive_enable & !continuous_receive_enable;        // [RULE_18]
    wire tx_go    = (txs == TX_IDLE) & hold_v & transmit_enable & pen
                    & (!sync | sync_tx);                     // [RULE_21]
    wire brk_go   = tx_go & sbrk & !sync;                    // [RULE_11]
    wire brk_done = (txs == TX_STOP) & tx_tick & tx_brk;     // [RULE_12]
    wire [TX_SH_W-1:0] load_val = brk_go ? '0 :
                                  sync   ? TX_SH_W'(hold) :
                                           TX_SH_W'({hold, 1'b0});
    wire [3:0] load_bits = brk_go ? BREAK_ZEROS + 4'h1 :     // [RULE_10]
                           sync   ? CHAR_BITS : CHAR_BITS + 4'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RST;
            baud <= BAUD_RESET;
        end else begin
            if (wr & hit_ctrl)
                ctrl <= pwdata[CTRL_W-1:0];
            if (wr & hit_baud)
                baud <= pwdata[BAUD_W-1:0];
            if (brk_done)
                ctrl[CB_SBRK] <= 1'b0;   // [RULE_12]
            if (wake_end)
                ctrl[CB_WUE] <= 1'b0;    // [RULE_05]
        end
    end

    // A write to a full holding register is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold   <= '0;
            hold_v <= 1'b0;
        end else if (tx_go) begin
            hold_v <= 1'b0;              // [RULE_21]
        end else if (wr & hit_txd & !hold_v) begin
            hold   <= pwdata[DATA_W-1:0];
            hold_v <= 1'b1;
        end
    end

    // Bit timer: one bit (async) or half a clock (sync) is baud+1 cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            tx_cnt <= '0;
        else if (txs == TX_IDLE || tx_tick)
            tx_cnt <= baud;
        else
            tx_cnt <= tx_cnt - 16'h0001;
    end

    // ------------------------------------------------------------
    // Transmit shifter and line drivers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txs           <= TX_IDLE;
            tx_sh         <= '0;
            tx_bits       <= '0;
            tx_brk        <= 1'b0;
            link.dev_ck_o <= 1'b1;
            link.dev_dt_o <= 1'b1;
        end else if (!pen) begin
            txs           <= TX_IDLE;
            link.dev_ck_o <= 1'b1;
        end else begin
            unique case (txs)
                TX_IDLE: begin
                    link.dev_ck_o <= sync ? pol : 1'b1;          // [RULE_20]
                    if (tx_go) begin
                        tx_sh   <= load_val;
                        tx_bits <= load_bits;
                        tx_brk  <= brk_go;
                        if (sync) begin
                            // Leading edge and first bit at once
                            link.dev_ck_o <= !pol;          // [RULE_22]
                            link.dev_dt_o <= hold[0];       // [RULE_23]
                            txs           <= TX_TRAIL;
                        end else begin
                            link.dev_ck_o <= 1'b0;          // [RULE_10]
                            txs           <= TX_ASYNC;
                        end
                    end
                end
                TX_ASYNC: if (tx_tick) begin
                    tx_sh   <= tx_sh >> 1;
                    tx_bits <= tx_bits - 4'h1;
                    if (tx_bits == 4'h1) begin
                        link.dev_ck_o <= 1'b1;
                        txs           <= TX_STOP;
                    end else begin
                        link.dev_ck_o <= tx_sh[1];
                    end
                end
                TX_STOP: if (tx_tick)
                    txs <= TX_IDLE;
                TX_TRAIL: if (tx_tick) begin
                    link.dev_ck_o <= pol;                   // [RULE_20]
                    tx_bits       <= tx_bits - 4'h1;
                    txs <= (tx_bits == 4'h1) ? TX_END : TX_LEAD;  // [RULE_19]
                end
                TX_LEAD: if (tx_tick) begin
                    link.dev_ck_o <= !pol;
                    link.dev_dt_o <= tx_sh[1];              // [RULE_22]
                    tx_sh         <= tx_sh >> 1;
                    txs           <= TX_TRAIL;
                end
                TX_END: if (tx_tick)
                    txs <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.dev_ck_oe <= 1'b0;
            link.dev_dt_oe <= 1'b0;
        end else begin
            link.dev_ck_oe <= pen & (!sync | mcs);
            link.dev_dt_oe <= sync_tx;                      // [RULE_17] [RULE_22]
        end
    end

    // ------------------------------------------------------------
    // Asynchronous receiver
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rx_sh;
    logic [3:0]        rx_bits;
    logic [BAUD_W-1:0] rx_cnt;

    wire rx_on   = pen & !sync & continuous_receive_enable & !wake_on_break_enable;               // [RULE_01]
    wire rx_tick = rx_cnt == '0;
    wire rx_done = (rxs == RX_STOP) & rx_tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxs     <= RX_IDLE;
            rx_sh   <= '0;
            rx_bits <= '0;
            rx_cnt  <= '0;
        end else if (!rx_on) begin
            rxs <= RX_IDLE;
        end else begin
            rx_cnt <= rx_tick ? baud : rx_cnt - 16'h0001;
            unique case (rxs)
                RX_IDLE: if (fell) begin
                    rx_cnt <= baud >> 1;
                    rxs    <= RX_START;
                end
                RX_START: if (rx_tick) begin
                    rx_bits <= '0;
                    rxs     <= dts ? RX_IDLE : RX_DATA;
                end
                RX_DATA: if (rx_tick) begin
                    rx_sh   <= {dts, rx_sh[DATA_W-1:1]};
                    rx_bits <= rx_bits + 4'h1;
                    if (rx_bits == CHAR_BITS - 4'h1)
                        rxs <= RX_STOP;
                end
                RX_STOP: if (rx_tick)
                    rxs <= RX_IDLE;
            endcase
        end
    end

    // Set beats the clearing read in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dtp     <= 1'b1;
            rflag   <= 1'b0;
            framing_error_flag    <= 1'b0;
            rx_data <= '0;
        end else begin
            dtp   <= dts;
            rflag <= wake_ev | rx_done | (rflag & !rd_rxd);  // [RULE_04] [RULE_16]
            if (rx_done) begin
                rx_data <= rx_sh;
                framing_error_flag    <= !dts;                            // [RULE_15]
            end else if (rd_rxd) begin
                framing_error_flag <= 1'b0;
            end
        end
    end
endmodule // sbw_port

// >>> sbw_remote.sv
/*
 * Remote node: async sender and sync slave receiver.
 * Assumes no sending while the port drives data.
 */
module sbw_remote
    import sbw_pkg::*;
#(
    parameter int BIT_CYCLES = REM_BIT_CYCLES,
    parameter int BREAK_BITS = LIN_BREAK_BITS
) (
    input  logic              pclk,
    input  logic              presetn,
    sbw_link_if.rem           link,
    input  logic              send_start,
    input  logic              send_break,
    input  logic [DATA_W-1:0] send_data,
    output logic              send_busy,
    input  logic              slave_en,
    input  logic              slave_pol,
    output logic              slave_valid,
    output logic [DATA_W-1:0] slave_data
);
    // A wake character shorter than this fragments at the port
    if (BREAK_BITS < WAKE_MIN_BITS || BREAK_BITS > 62) begin : g_chk_brk
        $error("BREAK_BITS out of range");  // [RULE_08]
    end
    if (BIT_CYCLES < 2) begin : g_chk_bit
        $error("BIT_CYCLES too small");
    end

    // ------------------------------------------------------------
    // Line sampling
    // ------------------------------------------------------------
    logic dts;
    logic cks;
    logic ckp;

    sbw_sync u_dt (.clk(pclk), .rst_n(presetn), .d(link.dt), .q(dts));
    sbw_sync u_ck (.clk(pclk), .rst_n(presetn), .d(link.ck), .q(cks));

    // ------------------------------------------------------------
    // Asynchronous sender
    // ------------------------------------------------------------
    logic [9:0]  tsh;
    logic [5:0]  tbits;
    logic [15:0] tcnt;
    wire         ttick = tcnt == '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tsh            <= '0;
            tbits          <= '0;
            tcnt           <= '0;
            send_busy      <= 1'b0;
            link.rem_dt_o  <= 1'b1;
            link.rem_dt_oe <= 1'b0;
        end else if (!send_busy) begin
            tcnt <= 16'(BIT_CYCLES - 1);
            if (send_start) begin
                // Break is all zeros so the port sees one clean edge pair
                tsh   <= send_break ? '0 : {1'b1, send_data, 1'b0};
                tbits <= send_break ? 6'(BREAK_BITS + 1) : 6'(DATA_W + 2);
                send_busy      <= 1'b1;
                link.rem_dt_o  <= 1'b0;  // [RULE_08]
                link.rem_dt_oe <= 1'b1;
            end
        end else if (ttick) begin
            tcnt  <= 16'(BIT_CYCLES - 1);
            tsh   <= tsh >> 1;
            tbits <= tbits - 6'h01;
            if (tbits == 6'h01) begin
                send_busy      <= 1'b0;
                link.rem_dt_oe <= 1'b0;
                link.rem_dt_o  <= 1'b1;
            end else begin
                link.rem_dt_o <= (tbits == 6'h02) ? 1'b1 : tsh[1];
            end
        end else begin
            tcnt <= tcnt - 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Synchronous slave receiver
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rsh;
    logic [3:0]        rbits;
    wire  trail = slave_pol ? (!ckp & cks) : (ckp & !cks);
    wire  [DATA_W-1:0] next_rsh = {dts, rsh[DATA_W-1:1]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ckp         <= 1'b1;
            rsh         <= '0;
            rbits       <= '0;
            slave_valid <= 1'b0;
            slave_data  <= '0;
        end else begin
            ckp         <= cks;
            slave_valid <= 1'b0;
            if (!slave_en) begin
                rbits <= '0;
            end else if (trail) begin
                rsh   <= next_rsh;  // [RULE_23]
                rbits <= rbits + 4'h1;
                if (rbits == CHAR_BITS - 4'h1) begin
                    // No start or stop framing: eight clocks make one byte
                    rbits       <= '0;  // [RULE_17]
                    slave_valid <= 1'b1;
                    slave_data  <= next_rsh;
                end
            end
        end
    end
endmodule // sbw_remote

// >>> sbw_sync.sv
/*
 * Two-stage synchroniser for a level from outside the clock domain.
 * Assumes the input may change at any time relative to clk.
 */
module sbw_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  logic clk,
    input  logic rst_n,
    input  logic d,
    output logic q
);
    logic meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= RST_VAL;
            q    <= RST_VAL;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // sbw_sync

// >>> test_serial_break_wake_sync_master.sv
/*
 * Self-checking bench for both ends.
 * Assumes default baud (8-cycle bits) on both ends.
 */
module test_serial_break_wake_sync_master
    import sbw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              pclk, presetn, psel, penable, pwrite, pready;
    logic              pslverr, err, send_start, send_break, send_busy;
    logic              slave_en, slave_pol, slave_valid;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [7:0]        send_data, slave_data, b;
    logic [16:0]       seed;
    logic [7:0]        exp_q[$];
    int                failures, checked, n;

    sbw_link_if link();
    sbw_port sbw_port_i(.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .link(link));
    sbw_remote sbw_remote_i(.pclk, .presetn, .link(link), .send_start,
        .send_break, .send_data, .send_busy, .slave_en, .slave_pol,
        .slave_valid, .slave_data);
    sbw_checker sbw_checker_i(.pclk, .presetn, .dev_dt_o(link.dev_dt_o),
        .dev_dt_oe(link.dev_dt_oe), .dev_ck_o(link.dev_ck_o),
        .dev_ck_oe(link.dev_ck_oe), .rem_dt_o(link.rem_dt_o),
        .rem_dt_oe(link.rem_dt_oe), .ck(link.ck));

    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic report_and_stop;
        if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, s);
        checked++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 20 && pready !== 1'b1; i++) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdchk(input [7:0] a, input [31:0] m, e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd & m);
    endtask
    task automatic send(input logic brk, input logic [7:0] d);
        send_start <= 1'b1;
        send_break <= brk;
        send_data <= d;
        @(posedge pclk);
        send_start <= 1'b0;
        @(posedge pclk);
    endtask

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        report_and_stop();
    end
    always @(posedge pclk) begin
        if (slave_valid === 1'b1) begin
            b = exp_q.size() > 0 ? exp_q.pop_front() : 8'hx;
            chk("slave_data", {24'h0, b}, {24'h0, slave_data});
        end
    end

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        {psel, penable, pwrite, send_start, send_break} = 5'h00;
        {slave_en, slave_pol, paddr, pwdata, send_data} = '0;
        {failures, checked, seed, presetn} = {32'h0, 32'h0, 17'h145cf, 1'b0};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(OFS_CTRL, 32'hffffffff, 32'h0, "ctrl");
        rdchk(OFS_BAUD, 32'hffffffff, 32'h7, "baud");
        rdchk(OFS_STAT, 32'h18, 32'h18, "stat_idle");
        apb(1'b0, 8'hfc, 32'h0);
        chk("unmapped", 32'h1, {rd[30:0], err});
        rdchk(OFS_STAT, 32'h4, 32'h4, "rx_idle");
        apb(1'b1, OFS_CTRL, 32'h121);
        send(1'b1, 8'hff);
        repeat (20) @(posedge pclk);
        rdchk(OFS_STAT, 32'h1, 32'h1, "wake_flag");
        for (n = 0; n < 300 && send_busy !== 1'b0; n++) @(posedge pclk);
        rdchk(OFS_STAT, 32'h3, 32'h1, "wake_only");
        rdchk(OFS_CTRL, 32'h20, 32'h0, "wake_clear");
        apb(1'b0, OFS_RXD, 32'h0);
        rdchk(OFS_STAT, 32'h1, 32'h0, "wake_ack");
        for (int k = 0; k < 2; k++) begin
            seed = lfsr(seed);
            send(k[0], seed[7:0]);
            for (n = 0; n < 300 && send_busy !== 1'b0; n++) @(posedge pclk);
            repeat (4) @(posedge pclk);
            rdchk(OFS_STAT, 32'h3, {30'h0, k[0], 1'b1}, "rx_st");
            rdchk(OFS_RXD, 32'hff, k ? 32'h0 : {24'h0, seed[7:0]},
                  "rx_data");
        end
        apb(1'b1, OFS_CTRL, 32'h19);
        fork
            begin
                seed = lfsr(seed);
                apb(1'b1, OFS_TXD, {15'h0, seed});
                apb(1'b1, OFS_TXD, 32'h55);
                rdchk(OFS_STAT, 32'h18, 32'h0, "tx_busy");
                rdchk(OFS_CTRL, 32'h10, 32'h10, "brk_held");
            end
            begin
                for (n = 0; n < 40 && link.ck; n++) @(posedge pclk);
                for (n = 0; n < 200 && !link.ck; n++) @(posedge pclk);
                chk("break_low", 32'h68, n);
                for (n = 0; n < 40 && link.ck; n++) @(posedge pclk);
                repeat (4) @(posedge pclk);
                for (int i = 0; i < 8; i++) begin
                    repeat (8) @(posedge pclk);
                    b[i] = link.ck;
                end
                chk("sync_byte", 32'h55, {24'h0, b});
            end
        join
        repeat (16) @(posedge pclk);
        rdchk(OFS_STAT, 32'h8, 32'h8, "tx_empty");
        rdchk(OFS_CTRL, 32'h10, 32'h0, "brk_clear");
        for (int p = 1; p >= 0; p--) begin
            apb(1'b1, OFS_CTRL, {25'h0, p[0], 6'h0f});
            slave_pol <= p[0];
            repeat (16) @(posedge pclk);
            chk("idle", {30'h1, p[0]}, {link.dev_dt_oe, link.ck});
            slave_en <= 1'b1;
            for (int j = 0; j < 2; j++) begin
                seed = lfsr(seed);
                exp_q.push_back(seed[7:0]);
                apb(1'b1, OFS_TXD, {24'h0, seed[7:0]});
            end
            for (n = 0; n < 400 && exp_q.size() > 0; n++) @(posedge pclk);
            chk("sync_left", 32'h0, exp_q.size());
            slave_en <= 1'b0;
            repeat (16) @(posedge pclk);
        end
        report_and_stop();
    end
endmodule // test_serial_break_wake_sync_master
